// [common/csfr_pkg.sv]
package csfr_pkg;
    // Register offsets within bank 0 (address bits 8 to 2).
    localparam logic [6:0] OFS_INDIRECT_PORT_0 = 7'h00;
    localparam logic [6:0] OFS_INDIRECT_PORT_1 = 7'h01;
    localparam logic [6:0] OFS_PC_LOW_BYTE = 7'h02;
    localparam logic [6:0] OFS_CORE_STATUS = 7'h03;
    localparam logic [6:0] OFS_POINTER_0_LOW = 7'h04;
    localparam logic [6:0] OFS_POINTER_0_HIGH = 7'h05;
    localparam logic [6:0] OFS_POINTER_1_LOW = 7'h06;
    localparam logic [6:0] OFS_POINTER_1_HIGH = 7'h07;
    localparam logic [6:0] OFS_BANK_SELECTOR = 7'h08;
    localparam logic [6:0] OFS_WORKING_ACC = 7'h09;
    localparam logic [6:0] OFS_PC_UPPER_HOLDING = 7'h0a;
    localparam logic [6:0] OFS_INTERRUPT_CONTROL = 7'h0b;
    // APB byte addresses of the block's own interrupt registers.
    localparam logic [11:0] APB_IRQ_STATUS = 12'hff0;
    localparam logic [11:0] APB_IRQ_MASK = 12'hff4;
    // Reset values.
    localparam logic [7:0] RST_CORE_STATUS = 8'h18;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // Writable bit masks.
    localparam logic [7:0] MASK_STATUS_RW = 8'h07;
    localparam logic [7:0] MASK_BANK = 8'h1f;
    localparam logic [7:0] MASK_HOLDING = 8'h7f;
    // Interrupt event bit positions.
    localparam int IRQ_PC_LOAD = 0;
    localparam int IRQ_IND_WR = 1;
    localparam int IRQ_BANK_CHG = 2;
    localparam int IRQ_BITS = 3;
endpackage

// [hdl/csfr_irq.sv]
`timescale 1ns/10ps
// Sticky interrupt status with mask; a read of status clears it.
module csfr_irq
    import csfr_pkg::*;
#(
    parameter int N = IRQ_BITS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [N-1:0] event_in,
    input wire logic status_rd,
    input wire logic mask_wr,
    input wire logic [N-1:0] mask_wdata,
    output logic [N-1:0] status_ff,
    output logic [N-1:0] mask_ff,
    output logic irq
);
    if (N < 1) begin : g_bad_n
        $error("csfr_irq needs at least one event");
    end

    // Each bit: an event in the clearing read cycle still wins.
    genvar gi;
    for (gi = 0; gi < N; gi++) begin : g_bit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                status_ff[gi] <= 1'b0;
            end else if (event_in[gi]) begin
                status_ff[gi] <= 1'b1;
            end else if (status_rd) begin
                status_ff[gi] <= 1'b0;
            end
        end
    end

    // Mask register, written by software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= '0;
        end else if (mask_wr) begin
            mask_ff <= mask_wdata;
        end
    end

    // Level output while any unmasked bit is set.
    assign irq = |(status_ff & mask_ff);
endmodule

// [hdl/csfr_bank.sv]
`timescale 1ns/10ps
module csfr_bank
    import csfr_pkg::*;
#(
    parameter int DMEM_AW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pc_load,
    input wire logic [7:0] pc_load_low,
    input wire logic [7:0] core_flags,
    input wire logic core_flags_we,
    input wire logic [7:0] interrupt_control_flags_set,
    output logic [14:0] pc_value,
    output logic [7:0] working_value,
    output logic dmem_req,
    output logic dmem_we,
    output logic [DMEM_AW-1:0] dmem_addr,
    output logic [7:0] dmem_wdata,
    input wire logic [7:0] dmem_rdata,
    input wire logic dmem_ack,
    output logic irq
);
    // The pointer pairs form a 16-bit address, so a narrower memory bus is refused.
    if (DMEM_AW < 16) begin : g_bad_aw
        $error("csfr_bank needs a 16-bit data-memory address");
    end

    // Access states: idle, or waiting on data memory.
    typedef enum logic [0:0] {CS_IDLE, CS_MEM} csfr_state_e;
    csfr_state_e state_ff;
    csfr_state_e nxt_state;

    // Core registers.
    logic [7:0] pc_low_ff;          // Low byte of the program counter.
    logic [6:0] pc_upper_ff;        // Upper program counter bits.
    logic [7:0] status_ff;          // Core status.
    logic [7:0] ptr0_low_ff;        // Pointer 0 low byte.
    logic [7:0] ptr0_high_ff;       // Pointer 0 high byte.
    logic [7:0] ptr1_low_ff;        // Pointer 1 low byte.
    logic [7:0] ptr1_high_ff;       // Pointer 1 high byte.
    logic [7:0] bank_ff;            // Bank selector.
    logic [7:0] working_accumulator_ff;            // Working accumulator.
    logic [7:0] holding_ff;         // Holding value for upper counter bits.
    logic [7:0] interrupt_control_ff;          // Interrupt control.
    logic [31:0] prdata_ff;         // Registered read data.
    logic mem_done_ff;              // Memory access answered.

    // Decode helpers.
    logic [6:0] ofs;                // Offset within a bank.
    logic core_hit;                 // Address lands on a core register.
    logic ind_hit;                  // Address lands on an indirect port.
    logic setup;                    // APB setup phase.
    logic access;                   // APB access phase.
    logic wr_lane;                  // Low byte lane enabled for a write.
    logic [7:0] wbyte;              // Written byte.
    logic reg_wr;                   // Completing write to a core register.
    logic irq_status_rd;            // Read of the interrupt status.
    logic irq_mask_wr;              // Write of the interrupt mask.
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_mask;
    logic [IRQ_BITS-1:0] irq_events;
    logic [7:0] reg_rdata;          // Core register read value.

    assign ofs = paddr[8:2];
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr_lane = pstrb[0];
    assign wbyte = pwdata[7:0];

    // The core block sits at the low offsets of bank 0 only (paddr[11:9] zero), regardless of selector.
    assign core_hit = (paddr[1:0] == 2'b00) && (ofs <= OFS_INTERRUPT_CONTROL)
                      && (paddr[11:9] == 3'b000);
    assign ind_hit = core_hit && ((ofs == OFS_INDIRECT_PORT_0)
                      || (ofs == OFS_INDIRECT_PORT_1));

    // Direct register writes finish in the first access cycle.
    assign reg_wr = access && pwrite && core_hit && !ind_hit && wr_lane;
    assign irq_status_rd = access && !pwrite && (paddr == APB_IRQ_STATUS) && pready;
    assign irq_mask_wr = access && pwrite && (paddr == APB_IRQ_MASK) && wr_lane;

    // Indirect accesses wait on memory; all else answers at once.
    assign pready = (state_ff == CS_MEM) ? mem_done_ff : !(access && ind_hit);
    assign pslverr = 1'b0;
    assign prdata = prdata_ff;

    // Next-state logic for indirect accesses.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            CS_IDLE: begin
                if (setup && ind_hit) begin
                    nxt_state = CS_MEM;
                end
            end
            CS_MEM: begin
                if (mem_done_ff) begin
                    nxt_state = CS_IDLE;
                end
            end
            default: begin
                nxt_state = CS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= CS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Data-memory request: pointer pair addresses the indirect access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dmem_req <= 1'b0;
            dmem_we <= 1'b0;
            dmem_addr <= '0;
            dmem_wdata <= RST_ZERO;
        end else if (state_ff == CS_IDLE && setup && ind_hit) begin
            dmem_req <= 1'b1;
            dmem_we <= pwrite && wr_lane;
            dmem_wdata <= wbyte;
            if (ofs == OFS_INDIRECT_PORT_0) begin
                dmem_addr <= DMEM_AW'({ptr0_high_ff, ptr0_low_ff});
            end else begin
                dmem_addr <= DMEM_AW'({ptr1_high_ff, ptr1_low_ff});
            end
        end else if (dmem_ack) begin
            dmem_req <= 1'b0;
        end
    end

    // Memory answer closes the APB access one cycle after the acknowledge.
    // The read byte itself goes straight into the read data register, so it
    // already stands in the cycle in which pready is high.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_done_ff <= 1'b0;
        end else begin
            mem_done_ff <= dmem_req && dmem_ack;
        end
    end

    // Program counter: the upper seven bits change only from the holding value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_low_ff <= RST_ZERO;
            pc_upper_ff <= 7'h00;
        end else if (pc_load) begin
            pc_low_ff <= pc_load_low;
            pc_upper_ff <= holding_ff[6:0];
        end else if (reg_wr && ofs == OFS_PC_LOW_BYTE) begin
            pc_low_ff <= wbyte;
            pc_upper_ff <= holding_ff[6:0];
        end
    end
    assign pc_value = {pc_upper_ff, pc_low_ff};

    // Holding register keeps seven bits; bit 7 stays zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            holding_ff <= RST_ZERO;
        end else if (reg_wr && ofs == OFS_PC_UPPER_HOLDING) begin
            holding_ff <= wbyte & MASK_HOLDING;
        end
    end

    // Status: core updates the low five flags and clears the top three; software writes only the low three.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= RST_CORE_STATUS;
        end else if (core_flags_we) begin
            status_ff <= core_flags & 8'h1f;
        end else if (reg_wr && ofs == OFS_CORE_STATUS) begin
            status_ff <= (status_ff & ~MASK_STATUS_RW) | (wbyte & MASK_STATUS_RW);
        end
    end

    // Pointer pairs.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr0_low_ff <= RST_ZERO;
            ptr0_high_ff <= RST_ZERO;
            ptr1_low_ff <= RST_ZERO;
            ptr1_high_ff <= RST_ZERO;
        end else if (reg_wr) begin
            if (ofs == OFS_POINTER_0_LOW) begin
                ptr0_low_ff <= wbyte;
            end else if (ofs == OFS_POINTER_0_HIGH) begin
                ptr0_high_ff <= wbyte;
            end else if (ofs == OFS_POINTER_1_LOW) begin
                ptr1_low_ff <= wbyte;
            end else if (ofs == OFS_POINTER_1_HIGH) begin
                ptr1_high_ff <= wbyte;
            end
        end
    end

    // Bank selector, working accumulator and interrupt control.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_ff <= RST_ZERO;
            working_accumulator_ff <= RST_ZERO;
            interrupt_control_ff <= RST_ZERO;
        end else begin
            if (reg_wr && ofs == OFS_BANK_SELECTOR) begin
                bank_ff <= wbyte & MASK_BANK;
            end
            if (reg_wr && ofs == OFS_WORKING_ACC) begin
                working_accumulator_ff <= wbyte;
            end
            // Hardware flag set wins over a software write in the same cycle.
            if (reg_wr && ofs == OFS_INTERRUPT_CONTROL) begin
                interrupt_control_ff <= wbyte | interrupt_control_flags_set;
            end else begin
                interrupt_control_ff <= interrupt_control_ff | interrupt_control_flags_set;
            end
        end
    end
    assign working_value = working_accumulator_ff;

    // Core register read mux; anything else reads zero.
    always_comb begin
        reg_rdata = RST_ZERO;
        if (ofs == OFS_PC_LOW_BYTE) begin
            reg_rdata = pc_low_ff;
        end else if (ofs == OFS_CORE_STATUS) begin
            reg_rdata = status_ff;
        end else if (ofs == OFS_POINTER_0_LOW) begin
            reg_rdata = ptr0_low_ff;
        end else if (ofs == OFS_POINTER_0_HIGH) begin
            reg_rdata = ptr0_high_ff;
        end else if (ofs == OFS_POINTER_1_LOW) begin
            reg_rdata = ptr1_low_ff;
        end else if (ofs == OFS_POINTER_1_HIGH) begin
            reg_rdata = ptr1_high_ff;
        end else if (ofs == OFS_BANK_SELECTOR) begin
            reg_rdata = bank_ff;
        end else if (ofs == OFS_WORKING_ACC) begin
            reg_rdata = working_accumulator_ff;
        end else if (ofs == OFS_PC_UPPER_HOLDING) begin
            reg_rdata = holding_ff;
        end else if (ofs == OFS_INTERRUPT_CONTROL) begin
            reg_rdata = interrupt_control_ff;
        end
    end

    // Read data registered at setup; indirect reads load when memory answers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= '0;
        end else if (dmem_req && dmem_ack) begin
            // Loaded at the acknowledge edge so the byte stands while pready is high.
            prdata_ff <= {24'h000000, dmem_rdata};
        end else if (setup && !pwrite) begin
            if (core_hit && !ind_hit) begin
                prdata_ff <= {24'h000000, reg_rdata};
            end else if (paddr == APB_IRQ_STATUS) begin
                // An event in the setup cycle is reported too, since this read clears it.
                prdata_ff <= {29'h0, irq_status | irq_events};
            end else if (paddr == APB_IRQ_MASK) begin
                prdata_ff <= {29'h0, irq_mask};
            end else begin
                prdata_ff <= '0;
            end
        end
    end

    // Events: counter load, completed indirect write, bank change.
    assign irq_events[IRQ_PC_LOAD] = pc_load;
    assign irq_events[IRQ_IND_WR] = dmem_req && dmem_ack && dmem_we;
    assign irq_events[IRQ_BANK_CHG] = reg_wr && (ofs == OFS_BANK_SELECTOR);

    csfr_irq #(.N(IRQ_BITS)) u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .event_in(irq_events),
        .status_rd(irq_status_rd),
        .mask_wr(irq_mask_wr),
        .mask_wdata(pwdata[IRQ_BITS-1:0]),
        .status_ff(irq_status),
        .mask_ff(irq_mask),
        .irq(irq)
    );
endmodule

// [tb/csfr_bank_properties.sv]
`timescale 1ns/10ps
// Watches the bank's bus face, its memory request and the counter outputs.
module csfr_bank_properties
    import csfr_pkg::*;
#(
    parameter int DMEM_AW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pc_load,
    input wire logic [7:0] pc_load_low,
    input wire logic [14:0] pc_value,
    input wire logic [7:0] working_value,
    input wire logic dmem_req,
    input wire logic dmem_we,
    input wire logic [DMEM_AW-1:0] dmem_addr,
    input wire logic [7:0] dmem_wdata,
    input wire logic dmem_ack
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // High in the setup cycle of a transfer.
    wire logic setup = psel && !penable;
    // High in the completing cycle of a write.
    wire logic wr_done = psel && penable && pready && pwrite;

    a_unmapped_zero: assert property (
        psel && penable && pready && !pwrite && paddr[11:9] != 3'h0 && paddr[11:4] != 8'hff
        |-> prdata == 32'h0) else $error("unmapped read not zero");
    a_direct_nowait: assert property (
        setup && paddr[11:3] != 9'h0 |=> pready && !dmem_req)
        else $error("direct access waited");
    a_indirect_stall: assert property (
        setup && paddr[11:3] == 9'h0 |=> dmem_req && !pready)
        else $error("indirect access made no request");
    a_req_held: assert property (
        dmem_req && !dmem_ack |=> dmem_req && $stable(dmem_addr) && $stable(dmem_we))
        else $error("memory request dropped or changed");
    a_ack_ready: assert property (
        dmem_req && dmem_ack |=> pready && !dmem_req)
        else $error("acknowledge did not finish transfer");
    a_ind_wdata: assert property (
        setup && pwrite && paddr[11:3] == 9'h0 |=> dmem_we && dmem_wdata == $past(pwdata[7:0]))
        else $error("indirect write data wrong");
    a_pc_load: assert property (
        pc_load |=> pc_value[7:0] == $past(pc_load_low)) else $error("counter load wrong");
    a_working_wr: assert property (
        wr_done && pstrb[0] && paddr == 12'h024 |=> working_value == $past(pwdata[7:0]))
        else $error("working register not written");
    a_upper_held: assert property (
        wr_done && paddr == 12'h028 && !pc_load |=> $stable(pc_value[14:8]))
        else $error("counter upper changed by holding write");
endmodule

bind csfr_bank csfr_bank_properties #(.DMEM_AW(DMEM_AW)) u_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pc_load(pc_load),
    .pc_load_low(pc_load_low), .pc_value(pc_value), .working_value(working_value),
    .dmem_req(dmem_req), .dmem_we(dmem_we), .dmem_addr(dmem_addr),
    .dmem_wdata(dmem_wdata), .dmem_ack(dmem_ack));

// [tb/testbench.sv]
`timescale 1ns/10ps
// Self-checking bench for the core register bank.
module testbench
    import csfr_pkg::*;
;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("Error %0t: got %h expected %h", $time, g, e); end end
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf;
    logic pready, pslverr, irq, dmem_req, dmem_we, seen_we;
    logic pc_load = 1'b0, dmem_ack = 1'b0;
    logic [7:0] pc_load_low = 8'h00, dmem_rdata = 8'h00, working_value, dmem_wdata;
    logic [7:0] mem_byte = 8'h00, seen_wdata;
    logic [15:0] dmem_addr, seen_addr;
    logic [14:0] pc_value, pc_exp = 15'h0;
    logic [7:0] shadow [12]; // Expected contents of the direct registers.
    int failures = 0, cmp_count = 0, stall = 0;
    wire logic go = dmem_req && !dmem_ack && stall == 0; // Memory answers at the next edge.

    csfr_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pc_load(pc_load), .pc_load_low(pc_load_low),
        .core_flags(8'h00), .core_flags_we(1'b0), .interrupt_control_flags_set(8'h00),
        .pc_value(pc_value), .working_value(working_value), .dmem_req(dmem_req),
        .dmem_we(dmem_we), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
        .dmem_rdata(dmem_rdata), .dmem_ack(dmem_ack), .irq(irq));

    // Clock of 100 ns period.
    initial forever #50 pclk = ~pclk;

    // Data memory stand-in: stalls at random, records the request, scrambles idle data.
    always @(posedge pclk) begin
        dmem_ack <= go;
        dmem_rdata <= go ? mem_byte : ~dmem_rdata;
        if (go) begin
            seen_addr <= dmem_addr;
            seen_we <= dmem_we;
            seen_wdata <= dmem_wdata;
            stall <= $urandom_range(3);
        end else if (dmem_req && stall != 0) begin
            stall <= stall - 1;
        end
    end

    // Writable bits of each direct register.
    function automatic logic [7:0] wmask(input int o);
        return o == 3 ? MASK_STATUS_RW : o == 8 ? MASK_BANK : o == 10 ? MASK_HOLDING : 8'hff;
    endfunction

    // One bus transfer, entered just after an edge; read data lands in rd.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // Waits as long as the slave needs; only the watchdog ends a hang.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Writes a direct register and tracks what the outputs must show.
    task automatic wr(input int o, input logic [7:0] d, input logic [3:0] s);
        apb(1'b1, 12'(o * 4), {24'h0, d}, s);
        if (s[0]) begin
            shadow[o] = d & wmask(o);
            if (o == 2) pc_exp = {shadow[10][6:0], d};
        end
        `CHK(pc_value, pc_exp)
        `CHK(working_value, shadow[9])
    endtask

    // Reads a direct register back in whatever bank is selected.
    task automatic rd_chk(input int o);
        apb(1'b0, 12'(o * 4), 32'h0, 4'hf);
        `CHK(rd, {24'h0, o == 3 ? shadow[3] | RST_CORE_STATUS : shadow[o]})
    endtask

    // Pulses a counter load for one cycle.
    task automatic pulse_load(input logic [7:0] b);
        pc_load <= 1'b1;
        pc_load_low <= b;
        @(posedge pclk);
        pc_load <= 1'b0;
        @(posedge pclk);
        pc_exp = {shadow[10][6:0], b};
        `CHK(pc_value, pc_exp)
    endtask

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        int o;
        logic [7:0] b;
        logic [11:0] ua [3];
        ua = '{12'h030, 12'h224, 12'hfe8};
        foreach (shadow[i]) shadow[i] = 8'h00;
        rd = $urandom(32'h1d847d4b);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (o = 2; o < 12; o++) rd_chk(o);
        // Random writes, some with the low strobe off, each read back.
        for (int i = 0; i < 40; i++) begin
            o = $urandom_range(10, 2);
            wr(o, 8'($urandom), (i % 8 == 7) ? 4'he : 4'hf);
            rd_chk(o);
        end
        // Holding write leaves the counter; a load then carries it up.
        wr(10, 8'hff, 4'hf);
        wr(8, 8'hff, 4'hf);
        rd_chk(8);
        pulse_load(8'($urandom));
        // Unmapped places take no write and read zero.
        foreach (ua[i]) begin
            apb(1'b1, ua[i], 32'h5a, 4'hf);
            apb(1'b0, ua[i], 32'h0, 4'hf);
            `CHK(rd, 32'h0)
        end
        rd_chk(9);
        // Both indirect ports, read then write, through fresh pointers.
        for (int k = 0; k < 4; k++) begin
            o = k % 2;
            wr(4 + 2 * o, 8'($urandom), 4'hf);
            wr(5 + 2 * o, 8'($urandom), 4'hf);
            mem_byte = 8'($urandom);
            b = 8'($urandom);
            apb(k >= 2, 12'(o * 4), {24'h0, b}, 4'hf);
            `CHK(seen_addr, {shadow[5 + 2 * o], shadow[4 + 2 * o]})
            `CHK(seen_we, k >= 2)
            if (k < 2) `CHK(rd, {24'h0, mem_byte})
            if (k >= 2) `CHK(seen_wdata, b)
        end
        // Interrupt: raise, read-to-clear, then a masked event.
        apb(1'b0, APB_IRQ_STATUS, 32'h0, 4'hf);
        apb(1'b1, APB_IRQ_MASK, 32'h1, 4'hf);
        `CHK(irq, 1'b0)
        pulse_load(8'h5a);
        `CHK(irq, 1'b1)
        apb(1'b0, APB_IRQ_STATUS, 32'h0, 4'hf);
        `CHK(rd, 32'h1)
        `CHK(irq, 1'b0)
        wr(8, 8'h03, 4'hf);
        `CHK(irq, 1'b0)
        apb(1'b0, APB_IRQ_STATUS, 32'h0, 4'hf);
        `CHK(rd, 32'h4)
        apb(1'b0, APB_IRQ_STATUS, 32'h0, 4'hf);
        `CHK(rd, 32'h0)
        `CHK(pslverr, 1'b0)
        tally_and_finish();
    end
endmodule
